//--- sfsp_core.sv
// Command sequencer for status access and page programming of a serial flash.
`timescale 1ns/1ps
`include "sfsp_defs.svh"

module sfsp_core #(
  parameter int WSR_CYCLES = `SFSP_WSR_CYCLES,
  parameter int PROG_CYCLES = `SFSP_PP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  output logic serial_out,
  output logic serial_out_oe,
  output logic [7:0] status_reg_one,
  output logic [7:0] status_reg_two,
  output logic array_wr_en,
  output logic [23:0] array_wr_addr,
  output logic [7:0] array_wr_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    return op == code;
  endfunction

  // Merge a status two write; lock bits only ever gain ones.
  function automatic logic [7:0] sr2_merge(input logic [7:0] old, input logic [7:0] nw,
                                           input logic vol);
    logic [7:0] res;
    res = (old & ~`SFSP_SR2_WR_MASK) | (nw & `SFSP_SR2_WR_MASK);
    res = res | (old & `SFSP_SR2_LOCK_MASK);
    if (vol) begin
      res = (res & ~`SFSP_SR2_LOCK_MASK) | (old & `SFSP_SR2_LOCK_MASK);
      res[`SFSP_SR2_STATUS_PROTECT_HIGH] = old[`SFSP_SR2_STATUS_PROTECT_HIGH];
    end
    return res;
  endfunction

  function automatic logic [7:0] sr1_merge(input logic [7:0] old, input logic [7:0] nw);
    return (old & ~`SFSP_SR1_WR_MASK) | (nw & `SFSP_SR1_WR_MASK);
  endfunction

  // Protected region grows from one end; complement inverts it.
  function automatic logic page_protected(input logic [23:0] a, input logic [7:0] s1,
                                          input logic cmp);
    logic [2:0] bp;
    logic [2:0] sh;
    logic [20:0] size;
    logic [20:0] off;
    logic hit;
    bp = s1[4:2];
    sh = (bp > 3'h4) ? 3'h3 : 3'(bp - 3'h1);
    size = (s1[`SFSP_SR1_SEC] ? `SFSP_SECT_BYTES : `SFSP_BLOCK_BYTES) << sh;
    off = {2'h0, a[18:0]};
    if (bp == 3'h0) begin
      hit = 1'b0;
    end else if (s1[`SFSP_SR1_TB]) begin
      hit = off < size;
    end else begin
      hit = off >= 21'(`SFSP_DEV_BYTES - size);
    end
    return cmp ? ~hit : hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: command capture on rising spi_clk.

  logic frame_live;
  logic frame_tgl;
  logic [2:0] bit_mod;
  logic [2:0] byte_cnt;
  logic [7:0] shreg;
  logic [7:0] link_op;
  logic [23:0] link_addr;
  logic [7:0] link_d1;
  logic [7:0] link_d2;
  logic [7:0] pg_ptr;
  logic [255:0] pg_mask;
  logic [7:0] pg_buf [0:255];
  logic [15:0] stat_pub;
  logic pub_req;
  logic req_s1;
  logic req_s2;
  logic pub_ack;
  logic [15:0] stat_copy;
  logic [2:0] eff_mod;
  logic [2:0] eff_byte;
  logic [7:0] next_shreg;
  logic byte_done;
  logic link_busy;
  logic pp_data;

  assign eff_mod = frame_live ? bit_mod : 3'h0;
  assign eff_byte = frame_live ? byte_cnt : 3'h0;
  assign next_shreg = {shreg[6:0], serial_in_line};
  assign byte_done = eff_mod == 3'h7;
  assign link_busy = stat_copy[`SFSP_SR1_BUSY];
  assign pp_data = byte_done && eff_byte >= 3'h4 && op_is(link_op, `SFSP_OP_PAGE_WRITE)
                   && !link_busy;

  // The spi_clk stops between frames, so the frame marker is cleared by chip select.
  always_ff @(posedge spi_clk or posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      frame_live <= 1'b0;
    end else if (cs_n) begin
      frame_live <= 1'b0;
    end else begin
      frame_live <= 1'b1;
    end
  end

  always_ff @(posedge spi_clk or negedge rstn) begin
    if (!rstn) begin
      frame_tgl <= 1'b0;
      bit_mod <= 3'h0;
      byte_cnt <= 3'h0;
      shreg <= 8'h00;
      link_op <= 8'h00;
      link_addr <= 24'h000000;
      link_d1 <= 8'h00;
      link_d2 <= 8'h00;
      pg_ptr <= 8'h00;
    end else begin
      if (!frame_live) begin
        frame_tgl <= ~frame_tgl;
      end
      bit_mod <= 3'(eff_mod + 3'h1);
      shreg <= next_shreg;
      if (byte_done) begin
        if (eff_byte != 3'h7) begin
          byte_cnt <= 3'(eff_byte + 3'h1);
        end
        case (eff_byte)
          3'h0: begin
            link_op <= next_shreg;
          end
          3'h1: begin
            link_addr[23:16] <= next_shreg;
            link_d1 <= next_shreg;
          end
          3'h2: begin
            link_addr[15:8] <= next_shreg;
            link_d2 <= next_shreg;
          end
          3'h3: begin
            link_addr[7:0] <= next_shreg;
            pg_ptr <= next_shreg;
          end
          default: begin
            if (pp_data) begin
              pg_ptr <= 8'(pg_ptr + 8'h01);
            end
          end
        endcase
      end else begin
        byte_cnt <= eff_byte;
      end
    end
  end

  // Mask of bytes loaded by the current program command; later bytes overwrite earlier ones.
  always_ff @(posedge spi_clk or negedge rstn) begin
    if (!rstn) begin
      pg_mask <= '0;
    end else if (byte_done && eff_byte == 3'h3 && op_is(link_op, `SFSP_OP_PAGE_WRITE)
                 && !link_busy) begin
      pg_mask <= '0;
    end else if (pp_data) begin
      pg_mask[pg_ptr] <= 1'b1;
    end
  end

  always_ff @(posedge spi_clk) begin
    if (pp_data) begin
      pg_buf[pg_ptr] <= next_shreg;
    end
  end

  // Status snapshot handshake; the first synchroniser stage feeds only the second.
  always_ff @(posedge spi_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      pub_ack <= 1'b0;
      stat_copy <= {`SFSP_SR2_RESET, `SFSP_SR1_RESET};
    end else begin
      req_s1 <= pub_req;
      req_s2 <= req_s1;
      if (req_s2 != pub_ack) begin
        stat_copy <= stat_pub;
        pub_ack <= req_s2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: status shift out on falling spi_clk.

  logic rd_ok;
  logic [7:0] rd_sel;
  logic [7:0] rd_hold;

  assign rd_ok = byte_cnt >= 3'h1 && (op_is(link_op, `SFSP_OP_READ_SR1)
                 || (op_is(link_op, `SFSP_OP_READ_SR2) && !link_busy));
  assign rd_sel = op_is(link_op, `SFSP_OP_READ_SR1) ? stat_copy[7:0] : stat_copy[15:8];

  always_ff @(negedge spi_clk or posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      rd_hold <= 8'h00;
    end else if (cs_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      rd_hold <= 8'h00;
    end else if (frame_live && rd_ok) begin
      serial_out_oe <= 1'b1;
      if (bit_mod == 3'h0) begin
        rd_hold <= rd_sel;
        serial_out <= rd_sel[7];
      end else begin
        serial_out <= rd_hold[3'h7 - bit_mod];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: frame end detection.

  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic ft_s1;
  logic ft_s2;
  logic ft_seen;
  logic ak_s1;
  logic ak_s2;
  logic frame_end;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ft_s1 <= 1'b0;
      ft_s2 <= 1'b0;
      ft_seen <= 1'b0;
      ak_s1 <= 1'b0;
      ak_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ft_s1 <= frame_tgl;
      ft_s2 <= ft_s1;
      ak_s1 <= pub_ack;
      ak_s2 <= ak_s1;
      if (cs_s2 && !cs_s3) begin
        ft_seen <= ft_s2;
      end
    end
  end

  // A chip select pulse without clocks carries no new frame and is ignored.
  assign frame_end = cs_s2 && !cs_s3 && (ft_s2 != ft_seen);

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: command decisions.

  sfsp_pkg::sfsp_state_t state;
  logic busy;
  logic write_latch_flag;
  logic vol_perm;
  logic aligned;
  logic one_byte;
  logic go_wren;
  logic go_wrdi;
  logic go_vwren;
  logic wsr_ok;
  logic go_vsr;
  logic go_nvsr;
  logic go_pp;
  logic wr_one;
  logic wr_two;
  logic [7:0] new_one;
  logic [7:0] new_two;

  assign busy = status_reg_one[`SFSP_SR1_BUSY];
  assign write_latch_flag = status_reg_one[`SFSP_SR1_WEL];
  assign aligned = bit_mod == 3'h0;
  assign one_byte = frame_end && !busy && aligned && byte_cnt == 3'h1;
  assign go_wren = one_byte && op_is(link_op, `SFSP_OP_WREN);
  assign go_wrdi = one_byte && op_is(link_op, `SFSP_OP_WRDI);
  assign go_vwren = one_byte && op_is(link_op, `SFSP_OP_VWREN);
  assign wsr_ok = frame_end && !busy && aligned && byte_cnt >= 3'h2 && byte_cnt <= 3'h4
                  && (op_is(link_op, `SFSP_OP_WSR1) || op_is(link_op, `SFSP_OP_WSR2));
  assign go_vsr = wsr_ok && vol_perm;
  assign go_nvsr = wsr_ok && !vol_perm && write_latch_flag;
  assign go_pp = frame_end && !busy && aligned && byte_cnt >= 3'h5 && write_latch_flag
                 && op_is(link_op, `SFSP_OP_PAGE_WRITE)
                 && !page_protected(link_addr, status_reg_one,
                                    status_reg_two[`SFSP_SR2_CMP]);
  // Opcode 01h takes register one first; a lone byte leaves register two alone.
  assign wr_one = op_is(link_op, `SFSP_OP_WSR1);
  assign wr_two = op_is(link_op, `SFSP_OP_WSR2) || byte_cnt >= 3'h3;
  assign new_one = link_d1;
  assign new_two = op_is(link_op, `SFSP_OP_WSR2) ? link_d1 : link_d2;

  // Any completed command other than the volatile enable itself spends the permission.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vol_perm <= 1'b0;
    end else if (frame_end && byte_cnt >= 3'h1) begin
      vol_perm <= go_vwren;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: timed cycles and array writes.

  logic [31:0] tmr;
  logic [8:0] prog_idx;
  logic [15:0] pg_base;
  logic pend_one;
  logic pend_two;
  logic [7:0] pend_one_val;
  logic [7:0] pend_two_val;
  logic cycle_done;

  assign cycle_done = state != sfsp_pkg::SFSP_IDLE && tmr == 32'h00000000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= sfsp_pkg::SFSP_IDLE;
      tmr <= 32'h00000000;
      prog_idx <= 9'h000;
      pg_base <= 16'h0000;
    end else begin
      case (state)
        sfsp_pkg::SFSP_IDLE: begin
          if (go_nvsr) begin
            state <= sfsp_pkg::SFSP_SRW;
            tmr <= 32'(WSR_CYCLES - 1);
          end else if (go_pp) begin
            state <= sfsp_pkg::SFSP_PROG;
            tmr <= 32'(PROG_CYCLES - 1);
            prog_idx <= 9'h000;
            pg_base <= link_addr[23:8];
          end
        end
        sfsp_pkg::SFSP_SRW, sfsp_pkg::SFSP_PROG: begin
          if (cycle_done) begin
            state <= sfsp_pkg::SFSP_IDLE;
          end else begin
            tmr <= 32'(tmr - 32'h00000001);
          end
          if (!prog_idx[8]) begin
            prog_idx <= 9'(prog_idx + 9'h001);
          end
        end
        default: begin
          state <= sfsp_pkg::SFSP_IDLE;
        end
      endcase
    end
  end

  // Buffered bytes leave during the first 256 cycles of the program cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      array_wr_en <= 1'b0;
      array_wr_addr <= 24'h000000;
      array_wr_data <= 8'h00;
    end else begin
      array_wr_en <= state == sfsp_pkg::SFSP_PROG && !prog_idx[8] && pg_mask[prog_idx[7:0]];
      array_wr_addr <= {pg_base, prog_idx[7:0]};
      array_wr_data <= pg_buf[prog_idx[7:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: status registers and their publication to the link.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_reg_one <= `SFSP_SR1_RESET;
      status_reg_two <= `SFSP_SR2_RESET;
      pend_one <= 1'b0;
      pend_two <= 1'b0;
      pend_one_val <= 8'h00;
      pend_two_val <= 8'h00;
    end else begin
      if (go_wren) begin
        status_reg_one[`SFSP_SR1_WEL] <= 1'b1;
      end
      if (go_wrdi) begin
        status_reg_one[`SFSP_SR1_WEL] <= 1'b0;
      end
      if (go_vsr) begin
        if (wr_one) begin
          status_reg_one <= sr1_merge(status_reg_one, new_one);
        end
        if (wr_two) begin
          status_reg_two <= sr2_merge(status_reg_two, new_two, 1'b1);
        end
      end
      if (go_nvsr) begin
        status_reg_one[`SFSP_SR1_BUSY] <= 1'b1;
        pend_one <= wr_one;
        pend_two <= wr_two;
        pend_one_val <= new_one;
        pend_two_val <= new_two;
      end
      if (go_pp) begin
        status_reg_one[`SFSP_SR1_BUSY] <= 1'b1;
      end
      if (cycle_done) begin
        if (state == sfsp_pkg::SFSP_SRW) begin
          if (pend_one) begin
            status_reg_one[7:2] <= pend_one_val[7:2];
          end
          if (pend_two) begin
            status_reg_two <= sr2_merge(status_reg_two, pend_two_val, 1'b0);
          end
        end
        status_reg_one[`SFSP_SR1_BUSY] <= 1'b0;
        status_reg_one[`SFSP_SR1_WEL] <= 1'b0;
      end
    end
  end

  // Snapshot is only replaced once the link has acknowledged the previous one.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_pub <= {`SFSP_SR2_RESET, `SFSP_SR1_RESET};
      pub_req <= 1'b0;
    end else if (pub_req == ak_s2 && stat_pub != {status_reg_two, status_reg_one}) begin
      stat_pub <= {status_reg_two, status_reg_one};
      pub_req <= ~pub_req;
    end
  end

endmodule

//--- sfsp_core_bench.sv
// Self-checking bench for the flash status and page program sequencer.
`timescale 1ns/1ps
module sfsp_core_bench;
  logic clk;
  logic rstn;
  logic spi_clk;
  logic cs_n;
  logic serial_in_line;
  logic serial_out;
  logic serial_out_oe;
  logic [7:0] status_reg_one;
  logic [7:0] status_reg_two;
  logic array_wr_en;
  logic [23:0] array_wr_addr;
  logic [7:0] array_wr_data;
  int mismatches;
  int checked;
  int wr_n;
  logic [15:0] rd;
  logic [7:0] mem [256];

  sfsp_core #(.WSR_CYCLES(60), .PROG_CYCLES(300)) sfsp_core_inst (
    .clk(clk), .rstn(rstn), .spi_clk(spi_clk), .cs_n(cs_n), .serial_in_line(serial_in_line),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .status_reg_one(status_reg_one),
    .status_reg_two(status_reg_two), .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
    .array_wr_data(array_wr_data));
  sfsp_host sfsp_host_inst (.spi_clk(spi_clk), .cs_n(cs_n), .serial_in_line(serial_in_line),
    .serial_out(serial_out));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check(what, {8'h00, seen}, {8'h00, exp});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Samples on the falling clock so registered outputs have settled.
  always @(negedge clk) begin
    if (array_wr_en === 1'b1) begin
      mem[array_wr_addr[7:0]] = array_wr_data;
      wr_n++;
      check("page", array_wr_addr[23:8], 16'h0001);
    end
  end

  task automatic send(input logic [7:0] q[$], input int extra = 0);
    @(posedge clk);
    sfsp_host_inst.xfer(q, extra, 0, rd);
  endtask

  task automatic rdsr(input logic [7:0] op);
    @(posedge clk);
    sfsp_host_inst.xfer('{op}, 0, 16, rd);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (status_reg_one[0] !== 1'b0 && n < 2000) begin
      #25 n++;
    end
    if (n >= 2000) begin
      check("timeout", 16'h0001, 16'h0000);
      end_of_test();
    end
    #100;
  endtask

  task automatic reset_dut();
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    #3 rstn = 1'b1;
    repeat (2) @(posedge clk);
    #3 chk8("sr1 reset", status_reg_one, 8'h00);
    chk8("sr2 reset", status_reg_two, 8'h00);
    $display("test reset done");
  endtask

  ////////////////////////////////////////
  task automatic t_latch();
    send('{8'h06});
    chk8("wel set", status_reg_one, 8'h02);
    rdsr(8'h05);
    check("read one", rd, 16'h0202);
    rdsr(8'h35);
    check("read two", rd, 16'h0000);
    send('{8'h04});
    chk8("wel clear", status_reg_one, 8'h00);
    send('{8'h06}, 1);
    chk8("wel ragged", status_reg_one, 8'h00);
    $display("test latch done");
  endtask

  task automatic t_srw();
    send('{8'h01, 8'hFC});
    chk8("srw no wel", status_reg_one, 8'h00);
    send('{8'h06});
    send('{8'h01, 8'hFF, 8'hFF, 8'h00});
    chk8("srw busy", status_reg_one, 8'h03);
    send('{8'h04});
    chk8("busy ignore", status_reg_one, 8'h03);
    rdsr(8'h05);
    chk8("poll", rd[15:8], 8'h03);
    wait_idle();
    chk8("srw sr1", status_reg_one, 8'hFC);
    chk8("srw sr2", status_reg_two, 8'h7B);
    $display("test status write done");
  endtask

  task automatic t_vol();
    send('{8'h50});
    chk8("vol no wel", status_reg_one, 8'hFC);
    send('{8'h01, 8'h00, 8'h00});
    chk8("vol sr1", status_reg_one, 8'h00);
    chk8("vol sr2", status_reg_two, 8'h39);
    send('{8'h06});
    send('{8'h31, 8'h00});
    wait_idle();
    chk8("otp sr2", status_reg_two, 8'h38);
    $display("test volatile done");
  endtask

  task automatic t_one();
    send('{8'h06});
    send('{8'h01, 8'hA0});
    wait_idle();
    chk8("one sr1", status_reg_one, 8'hA0);
    chk8("one sr2", status_reg_two, 8'h38);
    send('{8'h06});
    send('{8'h01, 8'hFF}, 4);
    chk8("ragged srw", status_reg_one, 8'hA2);
    send('{8'h04});
    send('{8'h50});
    rdsr(8'h05);
    check("repeat", rd, 16'hA0A0);
    send('{8'h01, 8'h00});
    chk8("vol lost", status_reg_one, 8'hA0);
    $display("test single byte done");
  endtask

  task automatic t_prot();
    wr_n = 0;
    send('{8'h50});
    send('{8'h01, 8'h1C});
    send('{8'h06});
    send('{8'h02, 8'h00, 8'h01, 8'h00, 8'hAA});
    chk8("protected", status_reg_one, 8'h1E);
    send('{8'h50});
    send('{8'h01, 8'h00});
    chk8("vol wel", status_reg_one, 8'h02);
    send('{8'h02, 8'h00, 8'h01, 8'h00, 8'hAA}, 3);
    chk8("ragged pp", status_reg_one, 8'h02);
    send('{8'h04});
    send('{8'h02, 8'h00, 8'h01, 8'h00, 8'hAA});
    chk8("pp no wel", status_reg_one, 8'h00);
    check("no writes", wr_n[15:0], 16'h0000);
    $display("test refused program done");
  endtask

  // Every location goes from the erased state once; the wrap overwrites two.
  task automatic t_prog();
    logic [7:0] q[$];
    q = '{8'h02, 8'h00, 8'h01, 8'hFE};
    for (int k = 0; k < 258; k++) begin
      q.push_back(k[7:0] ^ (k[8] ? 8'h55 : 8'h00));
    end
    wr_n = 0;
    send('{8'h06});
    send(q);
    chk8("pp busy", status_reg_one, 8'h03);
    wait_idle();
    chk8("pp done", status_reg_one, 8'h00);
    check("writes", wr_n[15:0], 16'h0100);
    for (int j = 0; j < 256; j++) begin
      chk8("byte", mem[j], (j == 254) ? 8'h55 : (j == 255) ? 8'h54 : 8'(j + 2));
    end
    $display("test page program done");
  endtask

  initial begin
    rstn = 1'b0;
    mismatches = 0;
    checked = 0;
    wr_n = 0;
    rd = 16'h0000;
    reset_dut();
    t_latch();
    t_srw();
    t_vol();
    t_one();
    t_prot();
    t_prog();
    send('{8'h06});
    reset_dut();
    end_of_test();
  end
endmodule

//--- sfsp_core_chk.sv
// Port checker for the flash status and page program sequencer.
`timescale 1ns/1ps
module sfsp_core_chk #(
  parameter int WSR_CYCLES = 20,
  parameter int PROG_CYCLES = 300
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic [7:0] status_reg_one,
  input wire logic [7:0] status_reg_two,
  input wire logic array_wr_en,
  input wire logic [23:0] array_wr_addr,
  input wire logic [7:0] array_wr_data
);
  localparam int LO = (WSR_CYCLES < PROG_CYCLES ? WSR_CYCLES : PROG_CYCLES) - 2;
  localparam int HI = (WSR_CYCLES > PROG_CYCLES ? WSR_CYCLES : PROG_CYCLES) + 4;
  int busy_len;
  logic [15:0] page;
  logic page_ok;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Busy runs far longer than a repetition may unroll, so it is counted.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_len <= 0;
    end else begin
      busy_len <= status_reg_one[0] ? busy_len + 1 : 0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page <= 16'h0000;
      page_ok <= 1'b0;
    end else if (array_wr_en) begin
      page <= array_wr_addr[23:8];
      page_ok <= 1'b1;
    end else if (!status_reg_one[0]) begin
      page_ok <= 1'b0;
    end
  end

  ////////////////////////////////////////
  AST_OE_IDLE: assert property (cs_n |-> !serial_out_oe)
    else $error("output enable high while deselected");
  AST_OUT_QUIET: assert property (!serial_out_oe |-> !serial_out)
    else $error("output line not low while undriven");
  AST_WEL_DONE: assert property (
    $fell(status_reg_one[0]) |-> ##[0:2] !status_reg_one[1])
    else $error("write latch kept after busy ended");
  AST_BUSY_LEN: assert property (
    $fell(status_reg_one[0]) |-> busy_len >= LO && busy_len <= HI)
    else $error("busy period of wrong length");
  AST_BUSY_WEL: assert property ($rose(status_reg_one[0]) |-> status_reg_one[1])
    else $error("busy started without write latch");
  AST_WEL_IDLE: assert property (
    $rose(status_reg_one[1]) |-> !$past(status_reg_one[0]))
    else $error("write latch set while busy");
  AST_LOCK_KEEP: assert property (
    (status_reg_two[5:3] & $past(status_reg_two[5:3])) == $past(status_reg_two[5:3]))
    else $error("lock bit returned to zero");
  AST_RO_ZERO: assert property (!status_reg_two[7] && !status_reg_two[2])
    else $error("read-only status bit changed");
  AST_WR_BUSY: assert property (array_wr_en |-> status_reg_one[0])
    else $error("array write outside busy");
  AST_WR_PAGE: assert property (
    array_wr_en && page_ok |-> array_wr_addr[23:8] == page)
    else $error("array write left its page");
  COV_BUSY: cover property ($rose(status_reg_one[0]));
  COV_WRITE: cover property (array_wr_en);
  COV_READ: cover property ($rose(serial_out_oe));
endmodule

bind sfsp_core sfsp_core_chk #(.WSR_CYCLES(WSR_CYCLES), .PROG_CYCLES(PROG_CYCLES)) sfsp_core_chk_inst (
  .clk(clk), .rstn(rstn), .spi_clk(spi_clk), .cs_n(cs_n), .serial_in_line(serial_in_line),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .status_reg_one(status_reg_one),
  .status_reg_two(status_reg_two), .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
  .array_wr_data(array_wr_data));

//--- sfsp_defs.svh
// Constants for the serial flash status and page program sequencer.
// Notes on behaviour
// - Opcode 05h/35h selects status read
// - Status byte shifted out MSB first, falling edge
// - Status one readable even while busy
// - Opcode 06h alone sets write latch flag
// - Program and non-volatile status write need latch flag
// - Volatile permission lost if another command intervenes
// - Volatile enable leaves write latch flag alone
// - Opcode 04h alone clears write latch flag
// - Latch flag cleared at reset and completion
// - Only writable status bit positions change
// - Lock bits once set stay set
// - Volatile write keeps lock and upper protect
// - Status write needs 8, 16, 24 data bits
// - Non-volatile status write runs timed busy cycle
// - Volatile status write applies instantly, no busy
// - One data byte after 01h writes register one only
// - Page program: 02h, 24-bit address, data
// - Page address wraps within 256 bytes
// - Program needs chip select on byte boundary
// - Valid program runs timed busy cycle
// - Protected target page makes program ignored
// - Status byte repeats while chip select low
`ifndef SFSP_DEFS_SVH
`define SFSP_DEFS_SVH

`define SFSP_OP_READ_SR1 8'h05
`define SFSP_OP_READ_SR2 8'h35
`define SFSP_OP_WREN 8'h06
`define SFSP_OP_WRDI 8'h04
`define SFSP_OP_VWREN 8'h50
`define SFSP_OP_WSR1 8'h01
`define SFSP_OP_WSR2 8'h31
`define SFSP_OP_PAGE_WRITE 8'h02

`define SFSP_SR1_BUSY 0
`define SFSP_SR1_WEL 1
`define SFSP_SR1_SEC 6
`define SFSP_SR1_TB 5
`define SFSP_SR2_STATUS_PROTECT_HIGH 0
`define SFSP_SR2_CMP 6
`define SFSP_SR1_WR_MASK 8'hFC
`define SFSP_SR2_WR_MASK 8'h7B
`define SFSP_SR2_LOCK_MASK 8'h38
`define SFSP_SR1_RESET 8'h00
`define SFSP_SR2_RESET 8'h00

`define SFSP_DEV_BYTES 21'h80000
`define SFSP_SECT_BYTES 21'h01000
`define SFSP_BLOCK_BYTES 21'h10000

`define SFSP_CLK_NS 25
`define SFSP_T_WSR_NS 1000000
`define SFSP_T_PP_NS 500000
`define SFSP_WSR_CYCLES ((`SFSP_T_WSR_NS + `SFSP_CLK_NS - 1) / `SFSP_CLK_NS)
`define SFSP_PP_CYCLES ((`SFSP_T_PP_NS + `SFSP_CLK_NS - 1) / `SFSP_CLK_NS)

`endif

//--- sfsp_host.sv
// Host controller model that drives frames onto the flash serial bus.
`timescale 1ns/1ps
module sfsp_host (
  output logic spi_clk,
  output logic cs_n,
  output logic serial_in_line,
  input wire logic serial_out
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    serial_in_line = 1'b0;
  end

  // Mode 0 frame: the clock stands low between frames, bits go out first.
  // Extra bits break the byte boundary on purpose; rdn bits are read back.
  task automatic xfer(input logic [7:0] q[$], input int extra, input int rdn,
                      output logic [15:0] rd);
    int n;
    n = q.size() * 8 + extra;
    rd = 16'h0000;
    #3 cs_n = 1'b0;
    for (int i = 0; i < n + rdn; i++) begin
      #1 serial_in_line = (i < q.size() * 8) ? q[i / 8][7 - i % 8] : 1'b0;
      #6.5 spi_clk = 1'b1;
      if (i >= n) begin
        rd = {rd[14:0], serial_out};
      end
      #7.5 spi_clk = 1'b0;
    end
    #7 cs_n = 1'b1;
    // A released line must not keep showing its last bit.
    serial_in_line = ~serial_in_line;
    #150;
  endtask
endmodule

//--- sfsp_pkg.sv
// Types shared by the serial flash status and page program sequencer.
package sfsp_pkg;
  typedef enum logic [1:0] {
    SFSP_IDLE = 2'h0,
    SFSP_SRW = 2'h1,
    SFSP_PROG = 2'h2
  } sfsp_state_t;
endpackage
